// ---- udu_defines.svh ----
// Constants for the unsigned divide, increment/decrement and AND unit.
`ifndef UDU_DEFINES_SVH
`define UDU_DEFINES_SVH
`define UDU_WORD_W 16
`define UDU_QUOT_LIMIT 16'hFFFF
`define UDU_ZERO_WORD 16'h0000
`define UDU_DIV_STEPS 5'h10
`define UDU_DIV32_STEPS 6'h20
`endif

// ---- udu_pkg.sv ----
// Types for the unsigned divide, increment/decrement and AND unit.
package udu_pkg;
	typedef enum logic [2:0] {
		UDU_OP_UDIV,
		UDU_OP_DDIV,
		UDU_OP_INC,
		UDU_OP_DEC,
		UDU_OP_AND,
		UDU_OP_NONE
	} udu_op_t;
	typedef enum logic [1:0] {
		UDU_IDLE,
		UDU_DIVIDE,
		UDU_FINISH
	} udu_state_t;
	typedef struct packed {
		udu_op_t op;
		logic [15:0] word_a;
		logic [15:0] word_a_hi;
		logic [15:0] word_b;
		logic dest_is_index;
	} udu_req_t;
	typedef struct packed {
		logic [15:0] data_c;
		logic [15:0] data_c1;
		logic [15:0] data_a;
		logic wr_c;
		logic wr_c1;
		logic wr_a;
		logic out_cond;
	} udu_res_t;
	typedef struct packed {
		udu_state_t st;
		udu_op_t op;
		logic [31:0] quo;
		logic [16:0] rem;
		logic [15:0] dvs;
		logic [5:0] cnt;
		logic index_dst;
		udu_res_t res;
		logic done;
		logic busy;
		logic err;
	} udu_regs_t;
endpackage

// ---- udu_unit.sv ----
// Execution unit for unsigned division, wrapping increment/decrement and bitwise AND.
// Summary of operation
// - Input on: A divided by B unsigned; quotient to C, remainder to C+1, output on.
// - Zero divisor: no writes, output off, error flag set.
// - Error flag is sticky; cleared only by explicit program reset request or by the resetn_in hardware reset.
// - Single-word divide into third index register keeps quotient, drops remainder.
// - Division words are all unsigned, never sign extended.
// - Input on: 32-bit A+1:A divided by B; quotient C, remainder C+1.
// - Quotient over 65535: write 65535 and 0, set error, output on.
// - Input on: increment writes A+1 back to A, output on.
// - Increment wraps 32767 to -32768.
// - Input on: decrement writes A-1 back to A, output on.
// - Decrement wraps -32768 to 32767.
// - Input on: C gets A AND B, output on.
// - Double word: higher-numbered word is upper half, lower-numbered word lower half.
`timescale 1ns/1ns
`include "udu_defines.svh"
module udu_unit (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic start_in,
	input wire logic input_cond_in,
	input wire udu_pkg::udu_req_t req_in,
	input wire logic error_flag_reset_in,
	output udu_pkg::udu_res_t res_out,
	output logic done_out,
	output logic busy_out,
	output logic instruction_error_flag_out
);
	udu_pkg::udu_regs_t s_r;
	udu_pkg::udu_regs_t s_nxt;
	logic [16:0] trial;
	logic [31:0] sum_a;
	logic err_raise;
	assign sum_a = {req_in.word_a_hi, req_in.word_a};
	// Restoring division, one quotient bit per clock, so no wide divider sits in one cycle.
	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		err_raise = 1'b0;
		trial = {s_r.rem[15:0], s_r.quo[31]} - {1'b0, s_r.dvs};
		unique case (s_r.st)
			udu_pkg::UDU_IDLE: begin
				if (start_in) begin
					s_nxt.res = '0;
					s_nxt.op = req_in.op;
					s_nxt.dvs = req_in.word_b;
					s_nxt.index_dst = req_in.dest_is_index;
					s_nxt.rem = '0;
					if (!input_cond_in) begin
						s_nxt.done = 1'b1;
					end else begin
						unique case (req_in.op)
							udu_pkg::UDU_OP_UDIV, udu_pkg::UDU_OP_DDIV: begin
								if (req_in.word_b == `UDU_ZERO_WORD) begin
									err_raise = 1'b1;
									s_nxt.done = 1'b1;
								end else begin
									s_nxt.st = udu_pkg::UDU_DIVIDE;
									s_nxt.busy = 1'b1;
									if (req_in.op == udu_pkg::UDU_OP_UDIV) begin
										s_nxt.quo = {req_in.word_a, `UDU_ZERO_WORD};
										s_nxt.cnt = {1'b0, `UDU_DIV_STEPS};
									end else begin
										s_nxt.quo = sum_a;
										s_nxt.cnt = `UDU_DIV32_STEPS;
									end
								end
							end
							udu_pkg::UDU_OP_INC: begin
								s_nxt.res.data_a = req_in.word_a + 16'h0001;
								s_nxt.res.wr_a = 1'b1;
								s_nxt.res.out_cond = 1'b1;
								s_nxt.done = 1'b1;
							end
							udu_pkg::UDU_OP_DEC: begin
								s_nxt.res.data_a = req_in.word_a - 16'h0001;
								s_nxt.res.wr_a = 1'b1;
								s_nxt.res.out_cond = 1'b1;
								s_nxt.done = 1'b1;
							end
							udu_pkg::UDU_OP_AND: begin
								s_nxt.res.data_c = req_in.word_a & req_in.word_b;
								s_nxt.res.wr_c = 1'b1;
								s_nxt.res.out_cond = 1'b1;
								s_nxt.done = 1'b1;
							end
							default: begin
								s_nxt.done = 1'b1;
							end
						endcase
					end
				end
			end
			udu_pkg::UDU_DIVIDE: begin
				if (s_r.rem[16] || !trial[16]) begin
					s_nxt.rem = {1'b0, trial[15:0]};
					s_nxt.quo = {s_r.quo[30:0], 1'b1};
				end else begin
					s_nxt.rem = {s_r.rem[15:0], s_r.quo[31]};
					s_nxt.quo = {s_r.quo[30:0], 1'b0};
				end
				s_nxt.cnt = s_r.cnt - 6'h01;
				if (s_r.cnt == 6'h01) begin
					s_nxt.st = udu_pkg::UDU_FINISH;
				end
			end
			udu_pkg::UDU_FINISH: begin
				s_nxt.st = udu_pkg::UDU_IDLE;
				s_nxt.busy = 1'b0;
				s_nxt.done = 1'b1;
				s_nxt.res.out_cond = 1'b1;
				s_nxt.res.wr_c = 1'b1;
				s_nxt.res.wr_c1 = !(s_r.op == udu_pkg::UDU_OP_UDIV && s_r.index_dst);
				if (s_r.op == udu_pkg::UDU_OP_DDIV && s_r.quo[31:16] != `UDU_ZERO_WORD) begin
					s_nxt.res.data_c = `UDU_QUOT_LIMIT;
					s_nxt.res.data_c1 = `UDU_ZERO_WORD;
					err_raise = 1'b1;
				end else begin
					s_nxt.res.data_c = s_r.quo[15:0];
					s_nxt.res.data_c1 = s_r.rem[15:0];
				end
			end
			default: begin
				s_nxt.st = udu_pkg::UDU_IDLE;
			end
		endcase
		// The clear loses to a same-cycle raise so no error event is dropped.
		s_nxt.err = err_raise || (s_r.err && !error_flag_reset_in);
	end
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
	assign res_out = s_r.res;
	assign done_out = s_r.done;
	assign busy_out = s_r.busy;
	assign instruction_error_flag_out = s_r.err;
endmodule // udu_unit

// ---- udu_unit_monitor.sv ----
// Checker bound to the divide, step and AND unit.
`timescale 1ns/1ns
module udu_unit_monitor (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic start_in,
	input wire logic input_cond_in,
	input wire udu_pkg::udu_req_t req_in,
	input wire logic error_flag_reset_in,
	input wire udu_pkg::udu_res_t res_out,
	input wire logic done_out,
	input wire logic busy_out,
	input wire logic instruction_error_flag_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	wire go = start_in && !busy_out;
	wire tk = go && input_cond_in;
	wire [2:0] op = req_in.op;
	wire nz = req_in.word_b != 16'h0000;
	a_off_idle: assert property (go && !input_cond_in && !error_flag_reset_in
		|=> done_out && res_out[3:0] == 4'h0 && $stable(instruction_error_flag_out)) else $error("off");
	a_inc_wrap: assert property (tk && op == 3'h2
		|=> res_out.wr_a && res_out.data_a == $past(req_in.word_a) + 16'h0001) else $error("inc");
	a_dec_wrap: assert property (tk && op == 3'h3
		|=> res_out.wr_a && res_out.data_a == $past(req_in.word_a) - 16'h0001) else $error("dec");
	a_and_word: assert property (tk && op == 3'h4
		|=> res_out.data_c == ($past(req_in.word_a) & $past(req_in.word_b))) else $error("and");
	a_zero_div: assert property (tk && op < 3'h2 && !nz
		|=> done_out && instruction_error_flag_out && res_out[3:0] == 4'h0) else $error("zero");
	a_udiv_time: assert property (tk && op == 3'h0 && nz
		|-> ##18 done_out && res_out.wr_c1 != $past(req_in.dest_is_index, 18)) else $error("udiv");
	a_ddiv_time: assert property (tk && op == 3'h1 && nz
		|-> ##34 done_out && res_out.out_cond && res_out.wr_c1) else $error("ddiv");
	a_err_sticky: assert property ($fell(instruction_error_flag_out)
		|-> $past(error_flag_reset_in)) else $error("flag");
endmodule // udu_unit_monitor
bind udu_unit udu_unit_monitor udu_unit_monitor_i (.*);

// ---- udu_seq.sv ----
// Scan sequencer model that issues one start strobe per scan request.
`timescale 1ns/1ns
module udu_seq (
	input wire logic clk_in,
	input wire logic go_in,
	output logic start_out = 1'b0
);
	// Registered so the strobe never moves on the edge that samples it.
	always @(posedge clk_in) start_out <= go_in;
endmodule // udu_seq

// ---- tb_top.sv ----
// Self-checking bench for the divide, step and AND unit.
`timescale 1ns/1ns
module tb_top;
	logic clk_in = 1'b0, resetn_in = 1'b0, go = 1'b0, cond = 1'b0, clr = 1'b0;
	logic start, done, busy, err;
	udu_pkg::udu_req_t rq = '0;
	udu_pkg::udu_res_t res;
	int error_cnt = 0, n_compared = 0, cyc = 0;
	logic [111:0] rows [11];
	logic [111:0] r;
	initial forever #2 clk_in = ~clk_in;
	udu_seq udu_seq_i (.clk_in(clk_in), .go_in(go), .start_out(start));
	udu_unit udu_unit_i (.clk_in(clk_in), .resetn_in(resetn_in), .start_in(start),
		.input_cond_in(cond), .req_in(rq), .error_flag_reset_in(clr), .res_out(res),
		.done_out(done), .busy_out(busy), .instruction_error_flag_out(err));
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic run_row(input logic [111:0] r, input bit late);
		@(posedge clk_in);
		clr <= r[1] && !late;
		go <= 1'b1;
		cond <= r[56];
		rq <= {r[110:60], r[57]};
		@(posedge clk_in);
		go <= 1'b0;
		clr <= r[1] && late;
		for (int k = 0; k < 45 && done !== 1'b1; k++) begin
			@(posedge clk_in);
			clr <= 1'b0;
			#1;
		end
		check(done, 1'b1);
		check(res, r[55:4]);
		check(err, r[0]);
	endtask
	task automatic summarize();
		$display("Compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			error_cnt++;
			summarize();
		end
	end
	initial begin
		// Fields: op, A, A+1, B, index/cond, C, C+1, A out, writes, clear/flag.
		rows = '{112'h0_D431_0000_012C_1_00B5_0015_0000_D_0,
			112'h1_11E1_0005_0FA0_1_0053_0101_0000_D_0,
			112'h0_D41C_0000_012C_3_00B5_0000_0000_9_0,
			112'h1_0000_0001_0001_1_FFFF_0000_0000_D_1,
			112'h2_7FFF_0000_0000_1_0000_0000_8000_3_1,
			112'h3_8000_0000_0000_1_0000_0000_7FFF_3_1,
			112'h4_3456_0000_FF00_1_3400_0000_0000_9_1,
			112'h0_D431_0000_012C_0_0000_0000_0000_0_1,
			112'h1_1234_0005_0000_1_0000_0000_0000_0_3,
			112'h0_D431_0000_012C_1_00B5_0015_0000_D_2,
			112'h5_1234_0000_5678_1_0000_0000_0000_0_0};
		repeat (2) @(posedge clk_in);
		resetn_in <= 1'b1;
		foreach (rows[i]) begin
			run_row(rows[i], 1'b0);
			$display("Test %0d done", i);
		end
		// A clear in the cycle of a raise must lose, with the flag raised and then kept up.
		repeat (2) run_row(rows[8], 1'b1);
		$display("Test clear against raise done");
		// A reset in mid-division must clear every output at once.
		@(posedge clk_in);
		rq <= {rows[0][110:60], rows[0][57]};
		cond <= 1'b1;
		go <= 1'b1;
		@(posedge clk_in);
		go <= 1'b0;
		repeat (5) @(posedge clk_in);
		check(busy, 1'b1);
		resetn_in <= 1'b0;
		#1;
		check({busy, done, err, res}, 64'h0);
		@(posedge clk_in);
		resetn_in <= 1'b1;
		run_row(rows[0], 1'b0);
		$display("Test reset done");
		summarize();
	end
endmodule // tb_top
